// *** src/sdis_pkg.sv ***
//----------------------------------------------------------------------
// Purpose: constants and types for the memory init / self-refresh host
// Assumes: memory clock is the system clock divided by two
// Notes: counts are in memory clock cycles (ticks)
//----------------------------------------------------------------------
package sdis_pkg;

   localparam int SYS_CLK_PERIOD_NS = 20;
   localparam int MEM_CLK_PERIOD_NS = 2 * SYS_CLK_PERIOD_NS;

   // times as printed
   localparam int INIT_PAUSE_US = 200;
   localparam int T_RP_NS = 20;
   localparam int T_MRS_CYC = 2;
   localparam int T_RAS_NS = 42;
   localparam int T_RC_NS = 70;

   // derived tick counts, least times rounded up
   localparam int INIT_PAUSE_TICKS = (INIT_PAUSE_US * 1000 + MEM_CLK_PERIOD_NS - 1)
                                     / MEM_CLK_PERIOD_NS;
   localparam logic [15:0] RP_TICKS =
      16'((T_RP_NS + MEM_CLK_PERIOD_NS - 1) / MEM_CLK_PERIOD_NS);
   localparam logic [15:0] MRS_TICKS = 16'(T_MRS_CYC);
   localparam logic [15:0] RAS_TICKS =
      16'((T_RAS_NS + MEM_CLK_PERIOD_NS - 1) / MEM_CLK_PERIOD_NS);
   localparam int RC_TICKS = (T_RC_NS + MEM_CLK_PERIOD_NS - 1) / MEM_CLK_PERIOD_NS;
   localparam logic [15:0] CLK_STABLE_TICKS = 16'h0002;
   localparam int SRX_TICKS = 1;

   localparam logic [11:0] INIT_REFRESHES = 12'h002;
   localparam logic [11:0] BURST_REFRESHES = 12'h800;

   localparam int ADDR_W = 13;
   localparam int PRECHARGE_ALL_BIT = 10;

   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
   } sdis_cmd_t;

   localparam sdis_cmd_t CMD_DESELECT = 4'hF;
   localparam sdis_cmd_t CMD_NOP = 4'h7;
   localparam sdis_cmd_t CMD_PRECHARGE = 4'h2;
   localparam sdis_cmd_t CMD_REFRESH = 4'h1;
   localparam sdis_cmd_t CMD_MODE_SET = 4'h0;

   typedef enum logic [3:0] {
      ST_POWERUP,
      ST_PRECHARGE,
      ST_MODE_SET,
      ST_REFRESH,
      ST_WAIT,
      ST_IDLE,
      ST_SR_ENTER,
      ST_SR_HOLD,
      ST_SR_EXIT
   } sdis_state_t;

endpackage

// *** src/sdis_ctrl.sv ***
//----------------------------------------------------------------------
// Purpose: drives a synchronous DRAM through power-up and self-refresh
// Assumes: memory clock made here as system clock divided by two
// Notes: commands change on the falling memory clock edge
//----------------------------------------------------------------------
`timescale 1ns/1ps

module sdis_ctrl #(
   parameter int INIT_PAUSE_TICKS = sdis_pkg::INIT_PAUSE_TICKS,
   parameter int SRX_TICKS = sdis_pkg::SRX_TICKS,
   parameter int RC_TICKS = sdis_pkg::RC_TICKS
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic sr_req_i,
   input wire logic burst_refresh_i,
   input wire logic [12:0] mode_word_i,
   output logic init_done_o,
   output logic self_refresh_o,
   output logic mem_clk_o,
   output logic mem_cke_o,
   output logic mem_cs_n_o,
   output logic mem_ras_n_o,
   output logic mem_cas_n_o,
   output logic mem_we_n_o,
   output logic [1:0] mem_ba_o,
   output logic [12:0] mem_addr_o,
   output logic [3:0] mem_dqm_o
);

   //-------------------------------------------------------------------
   // clock divider
   //-------------------------------------------------------------------
   logic phase_q;
   logic clk_run_q;
   logic clk_run_d;
   logic mem_clk_q;
   wire tick = phase_q;

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         phase_q <= 1'b0;
         mem_clk_q <= 1'b0;
         clk_run_q <= 1'b1;
      end
      else
      begin
         phase_q <= ~phase_q;
         mem_clk_q <= clk_run_q & ~phase_q;
         clk_run_q <= clk_run_d;
      end
   end

   //-------------------------------------------------------------------
   // sequencer
   //-------------------------------------------------------------------
   sdis_pkg::sdis_state_t state_q, state_d, next_q, next_d;
   sdis_pkg::sdis_cmd_t cmd_q, cmd_d;
   logic [15:0] cnt_q, cnt_d;
   logic [11:0] ref_left_q, ref_left_d;
   logic ref_to_sr_q, ref_to_sr_d;
   logic cke_q, cke_d;
   logic [12:0] addr_q, addr_d;
   logic init_done_q;
   logic sr_q;

   localparam logic [15:0] INIT_LOAD = 16'(INIT_PAUSE_TICKS - 1);
   localparam logic [15:0] EXIT_LOAD = 16'(SRX_TICKS + RC_TICKS - 1);
   localparam logic [15:0] RC_LOAD = 16'(RC_TICKS - 1);

   wire cnt_zero = (cnt_q == 16'h0000);
   wire last_ref = (ref_left_q == 12'h001);
   wire sdis_pkg::sdis_state_t after_ref =
      ref_to_sr_q ? sdis_pkg::ST_SR_ENTER : sdis_pkg::ST_IDLE;
   wire [11:0] burst_count = burst_refresh_i ? sdis_pkg::BURST_REFRESHES : 12'h000;

   always_comb
   begin
      state_d = state_q;
      next_d = next_q;
      cmd_d = cmd_q;
      cnt_d = cnt_q;
      ref_left_d = ref_left_q;
      ref_to_sr_d = ref_to_sr_q;
      cke_d = cke_q;
      addr_d = addr_q;
      clk_run_d = clk_run_q;
      if (tick)
      begin
         cmd_d = cke_q ? sdis_pkg::CMD_NOP : sdis_pkg::CMD_DESELECT;
         unique case (state_q)
            sdis_pkg::ST_POWERUP:
            begin
               if (cnt_zero)
                  state_d = sdis_pkg::ST_PRECHARGE;
               else
                  cnt_d = cnt_q - 16'h0001;
            end
            sdis_pkg::ST_PRECHARGE:
            begin
               cmd_d = sdis_pkg::CMD_PRECHARGE;
               addr_d = 13'h0001 << sdis_pkg::PRECHARGE_ALL_BIT;
               state_d = sdis_pkg::ST_WAIT;
               cnt_d = sdis_pkg::RP_TICKS - 16'h0001;
               if (!init_done_q)
                  next_d = sdis_pkg::ST_MODE_SET;
               else if (burst_refresh_i)
               begin
                  next_d = sdis_pkg::ST_REFRESH;
                  ref_left_d = burst_count;
                  ref_to_sr_d = 1'b1;
               end
               else
                  next_d = sdis_pkg::ST_SR_ENTER;
            end
            sdis_pkg::ST_MODE_SET:
            begin
               cmd_d = sdis_pkg::CMD_MODE_SET;
               addr_d = mode_word_i;
               state_d = sdis_pkg::ST_WAIT;
               cnt_d = sdis_pkg::MRS_TICKS - 16'h0001;
               next_d = sdis_pkg::ST_REFRESH;
               ref_left_d = sdis_pkg::INIT_REFRESHES;
               ref_to_sr_d = 1'b0;
            end
            sdis_pkg::ST_REFRESH:
            begin
               cmd_d = sdis_pkg::CMD_REFRESH;
               ref_left_d = ref_left_q - 12'h001;
               state_d = sdis_pkg::ST_WAIT;
               cnt_d = RC_LOAD;
               next_d = last_ref ? after_ref : sdis_pkg::ST_REFRESH;
            end
            sdis_pkg::ST_WAIT:
            begin
               // a wait that follows the exit deselect keeps chip select high
               if (cmd_q == sdis_pkg::CMD_DESELECT)
                  cmd_d = sdis_pkg::CMD_DESELECT;
               if (cnt_zero)
                  state_d = next_q;
               else
                  cnt_d = cnt_q - 16'h0001;
            end
            sdis_pkg::ST_IDLE:
            begin
               if (sr_req_i)
                  state_d = sdis_pkg::ST_PRECHARGE;
            end
            sdis_pkg::ST_SR_ENTER:
            begin
               cmd_d = sdis_pkg::CMD_REFRESH;
               cke_d = 1'b0;
               state_d = sdis_pkg::ST_SR_HOLD;
               cnt_d = sdis_pkg::RAS_TICKS - 16'h0001;
            end
            sdis_pkg::ST_SR_HOLD:
            begin
               clk_run_d = 1'b0;
               if (!cnt_zero)
                  cnt_d = cnt_q - 16'h0001;
               else if (!sr_req_i)
               begin
                  clk_run_d = 1'b1;
                  state_d = sdis_pkg::ST_WAIT;
                  cnt_d = sdis_pkg::CLK_STABLE_TICKS - 16'h0001;
                  next_d = sdis_pkg::ST_SR_EXIT;
               end
            end
            sdis_pkg::ST_SR_EXIT:
            begin
               cke_d = 1'b1;
               cmd_d = sdis_pkg::CMD_DESELECT;
               state_d = sdis_pkg::ST_WAIT;
               cnt_d = EXIT_LOAD;
               ref_to_sr_d = 1'b0;
               if (burst_refresh_i)
               begin
                  next_d = sdis_pkg::ST_REFRESH;
                  ref_left_d = burst_count;
               end
               else
                  next_d = sdis_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         state_q <= sdis_pkg::ST_POWERUP;
         next_q <= sdis_pkg::ST_POWERUP;
         cmd_q <= sdis_pkg::CMD_NOP;
         cnt_q <= INIT_LOAD;
         ref_left_q <= 12'h000;
         ref_to_sr_q <= 1'b0;
         cke_q <= 1'b1;
         addr_q <= 13'h0000;
      end
      else
      begin
         state_q <= state_d;
         next_q <= next_d;
         cmd_q <= cmd_d;
         cnt_q <= cnt_d;
         ref_left_q <= ref_left_d;
         ref_to_sr_q <= ref_to_sr_d;
         cke_q <= cke_d;
         addr_q <= addr_d;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         init_done_q <= 1'b0;
         sr_q <= 1'b0;
      end
      else
      begin
         init_done_q <= init_done_q | (state_q == sdis_pkg::ST_IDLE);
         sr_q <= ~cke_q;
      end
   end

   //-------------------------------------------------------------------
   // outputs
   //-------------------------------------------------------------------
   assign mem_clk_o = mem_clk_q;
   assign mem_cke_o = cke_q;
   assign mem_cs_n_o = cmd_q.cs_n;
   assign mem_ras_n_o = cmd_q.ras_n;
   assign mem_cas_n_o = cmd_q.cas_n;
   assign mem_we_n_o = cmd_q.we_n;
   assign mem_ba_o = 2'h0;
   assign mem_addr_o = addr_q;
   assign mem_dqm_o = 4'hF;
   assign init_done_o = init_done_q;
   assign self_refresh_o = sr_q;

   //-------------------------------------------------------------------
   // checks
   //-------------------------------------------------------------------
   logic [15:0] age_q;
   logic any_cmd_q;
   logic pre_seen_q;
   logic [2:0] refs_q;
   wire cmd_active = (cmd_q.cs_n == 1'b0) && (cmd_q != sdis_pkg::CMD_NOP);

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         age_q <= 16'h0000;
         any_cmd_q <= 1'b0;
         pre_seen_q <= 1'b0;
         refs_q <= 3'h0;
      end
      else
      begin
         if (tick && age_q != 16'hFFFF)
            age_q <= age_q + 16'h0001;
         any_cmd_q <= any_cmd_q | cmd_active;
         pre_seen_q <= pre_seen_q | (cmd_q == sdis_pkg::CMD_PRECHARGE);
         if ($rose(cmd_q == sdis_pkg::CMD_REFRESH) && refs_q != 3'h7)
            refs_q <= refs_q + 3'h1;
      end
   end

   powerup_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      state_q == sdis_pkg::ST_POWERUP |-> cmd_q == sdis_pkg::CMD_NOP && cke_q && mem_dqm_o == 4'hF)
      else $error("inputs not quiet during power-up pause");
   clock_toggles_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $past(rst_n_i) && clk_run_q && $past(clk_run_q) && $past(clk_run_q, 2)
      |-> mem_clk_q != $past(mem_clk_q))
      else $error("memory clock not toggling");
   init_pause_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(cmd_active) && !any_cmd_q |-> age_q >= 16'(INIT_PAUSE_TICKS))
      else $error("init command before power-up pause");
   first_precharge_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      cmd_active && !any_cmd_q |-> cmd_q == sdis_pkg::CMD_PRECHARGE && addr_q[10])
      else $error("first command is not precharge all");
   mode_after_pre_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      cmd_q == sdis_pkg::CMD_MODE_SET |-> pre_seen_q)
      else $error("mode load before precharge");
   init_refresh_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(init_done_q) |-> refs_q >= 3'h2)
      else $error("init finished with too few refreshes");
   mode_gap_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(cmd_q == sdis_pkg::CMD_MODE_SET) |-> ##2 (cmd_q == sdis_pkg::CMD_NOP) [*4])
      else $error("command too soon after mode load");
   sr_entry_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $fell(cke_q) |-> cmd_q == sdis_pkg::CMD_REFRESH)
      else $error("clock gate dropped without refresh command");
   sr_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $fell(cke_q) |-> (!cke_q) [*4])
      else $error("self-refresh left before row-active time");
   clk_stable_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(cke_q) |-> $past(clk_run_q, 1) && $past(clk_run_q, 4))
      else $error("clock gate raised before clock settled");
   exit_deselect_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(cke_q) |-> (cmd_q.cs_n) [*6])
      else $error("command issued during self-refresh exit");

endmodule

// *** test/sdis_mem_model.sv ***
//----------------------------------------------------------------------
// Purpose: behavioural memory device watching the init / self-refresh host
// Assumes: commands sampled on the rising memory clock
// Notes: counts protocol faults in err_cnt_o instead of printing
//----------------------------------------------------------------------
`timescale 1ns/1ps

module sdis_mem_model #(
   parameter int PAUSE_TICKS = 8,
   parameter int RC_TICKS = 2
) (
   input wire logic mem_clk_i,
   input wire logic mem_cke_i,
   input wire logic mem_cs_n_i,
   input wire logic mem_ras_n_i,
   input wire logic mem_cas_n_i,
   input wire logic mem_we_n_i,
   input wire logic [12:0] mem_addr_i,
   input wire logic [3:0] mem_dqm_i,
   output int err_cnt_o,
   output int ref_cnt_o,
   output logic init_ok_o,
   output logic in_sr_o,
   output logic [12:0] mode_q_o
);
   wire sdis_pkg::sdis_cmd_t cmd = {mem_cs_n_i, mem_ras_n_i, mem_cas_n_i, mem_we_n_i};
   wire idle_cmd = (cmd.cs_n === 1'b1) || (cmd === sdis_pkg::CMD_NOP);
   int phase, nop_ticks, gap, sr_rises, quiet;
   realtime sr_start;

   initial
   begin
      err_cnt_o = 0;
      ref_cnt_o = 0;
      init_ok_o = 1'b0;
      in_sr_o = 1'b0;
      mode_q_o = '0;
      phase = 0;
      nop_ticks = 0;
      gap = 0;
      quiet = 0;
   end

   //----------------------------------------------------------------------
   // command decoder
   //----------------------------------------------------------------------
   always @(posedge mem_clk_i)
   begin
      if (in_sr_o)
      begin
         // only the clock gate is watched here, and chip select on the exit tick
         sr_rises++;
         if (mem_cke_i === 1'b1)
         begin
            in_sr_o = 1'b0;
            if ($realtime - sr_start < sdis_pkg::T_RAS_NS) err_cnt_o++;
            if (sr_rises < 3 || mem_cs_n_i !== 1'b1) err_cnt_o++;
            quiet = RC_TICKS;
         end
      end
      else
      begin
         if (mem_dqm_i !== 4'hF) err_cnt_o++;
         if (mem_cke_i !== 1'b1)
         begin
            if (cmd !== sdis_pkg::CMD_REFRESH || phase != 3) err_cnt_o++;
            in_sr_o = 1'b1;
            sr_start = $realtime;
            sr_rises = 0;
         end
         else if (quiet > 0)
         begin
            if (!idle_cmd) err_cnt_o++;
            quiet--;
         end
         else if (idle_cmd)
         begin
            if (phase == 0 && cmd !== sdis_pkg::CMD_NOP) err_cnt_o++;
            nop_ticks++;
            gap++;
         end
         else
         begin
            case (phase)
               0:
               begin
                  if (nop_ticks < PAUSE_TICKS) err_cnt_o++;
                  if (cmd !== sdis_pkg::CMD_PRECHARGE || mem_addr_i[10] !== 1'b1) err_cnt_o++;
                  phase = 1;
               end
               1:
               begin
                  if (cmd !== sdis_pkg::CMD_MODE_SET) err_cnt_o++;
                  mode_q_o = mem_addr_i;
                  gap = 0;
                  phase = 2;
               end
               2:
               begin
                  if (cmd !== sdis_pkg::CMD_REFRESH || gap < 2) err_cnt_o++;
                  ref_cnt_o++;
                  if (ref_cnt_o >= 2) phase = 3;
                  init_ok_o = (ref_cnt_o >= 2);
               end
               default:
               begin
                  if (cmd === sdis_pkg::CMD_REFRESH) ref_cnt_o++;
                  else if (cmd !== sdis_pkg::CMD_PRECHARGE || mem_addr_i[10] !== 1'b1) err_cnt_o++;
               end
            endcase
         end
      end
   end
endmodule

// *** test/sdis_ctrl_test.sv ***
//----------------------------------------------------------------------
// Purpose: self-checking bench for the memory init / self-refresh host
// Assumes: shortened power-up pause, inputs driven on falling clk edge
// Notes: memory side is judged by the behavioural device model
//----------------------------------------------------------------------
`timescale 1ns/1ps

module sdis_ctrl_test;
   localparam int PAUSE = 8;
   localparam int SRX = 1;
   localparam int RC = 2;
   logic clk_sys_i, rst_n_i, sr_req_i, burst_refresh_i;
   logic [12:0] mode_word_i, mode_q, mem_addr_o;
   logic init_done_o, self_refresh_o, mem_clk_o, mem_cke_o, init_ok, in_sr, last_clk;
   logic mem_cs_n_o, mem_ras_n_o, mem_cas_n_o, mem_we_n_o;
   logic [1:0] mem_ba_o;
   logic [3:0] mem_dqm_o;
   int err_cnt, ref_cnt, bad_count, tests_run, seed, base, burst_n;

   sdis_ctrl #(.INIT_PAUSE_TICKS(PAUSE), .SRX_TICKS(SRX), .RC_TICKS(RC)) i_dut (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sr_req_i(sr_req_i),
      .burst_refresh_i(burst_refresh_i), .mode_word_i(mode_word_i),
      .init_done_o(init_done_o), .self_refresh_o(self_refresh_o), .mem_clk_o(mem_clk_o),
      .mem_cke_o(mem_cke_o), .mem_cs_n_o(mem_cs_n_o), .mem_ras_n_o(mem_ras_n_o),
      .mem_cas_n_o(mem_cas_n_o), .mem_we_n_o(mem_we_n_o), .mem_ba_o(mem_ba_o),
      .mem_addr_o(mem_addr_o), .mem_dqm_o(mem_dqm_o));

   sdis_mem_model #(.PAUSE_TICKS(PAUSE), .RC_TICKS(RC)) i_mem (
      .mem_clk_i(mem_clk_o), .mem_cke_i(mem_cke_o), .mem_cs_n_i(mem_cs_n_o),
      .mem_ras_n_i(mem_ras_n_o), .mem_cas_n_i(mem_cas_n_o), .mem_we_n_i(mem_we_n_o),
      .mem_addr_i(mem_addr_o), .mem_dqm_i(mem_dqm_o), .err_cnt_o(err_cnt),
      .ref_cnt_o(ref_cnt), .init_ok_o(init_ok), .in_sr_o(in_sr), .mode_q_o(mode_q));

   initial
   begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end

   //----------------------------------------------------------------------
   // shared tasks
   //----------------------------------------------------------------------
   task automatic end_sim;
      if (bad_count == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR at %0t got %0h expected %0h", $time, got, exp);
      end
   endtask

   // sel 0: init done, 1: self-refresh flag equals target, 2: refresh count equals target
   task automatic wait_until(input int sel, input int target);
      int n;
      logic hit;
      n = 0;
      hit = 1'b0;
      while (!hit && n < 40000)
      begin
         @(negedge clk_sys_i);
         n++;
         hit = (sel == 0) ? (init_done_o === 1'b1) :
               (sel == 1) ? (self_refresh_o === target[0]) : (ref_cnt == target);
      end
      if (!hit)
      begin
         bad_count++;
         $display("ERROR at %0t wait %0h timed out target %0h", $time, sel, target);
         end_sim();
      end
   endtask

   //----------------------------------------------------------------------
   // main sequence
   //----------------------------------------------------------------------
   initial
   begin
      bad_count = 0;
      tests_run = 0;
      seed = 60686;
      rst_n_i = 1'b0;
      sr_req_i = 1'b1;
      burst_refresh_i = 1'b0;
      mode_word_i = 13'($random(seed));
      repeat (16) @(negedge clk_sys_i);
      check({mem_cke_o, mem_cs_n_o, mem_ras_n_o, mem_cas_n_o, mem_we_n_o, mem_dqm_o}, 32'h17F);
      rst_n_i = 1'b1;
      repeat (2) @(negedge clk_sys_i);
      last_clk = ~mem_clk_o;
      @(negedge clk_sys_i);
      check(mem_clk_o, last_clk);
      // the early self-refresh request must wait for init to finish
      wait_until(0, 1);
      check(init_ok, 1'b1);
      check(mode_q, mode_word_i);
      check(mem_ba_o, 32'h0);
      check(32'(ref_cnt), 32'h2);
      for (int i = 0; i < 4; i++)
      begin
         burst_refresh_i = (i == 2);
         burst_n = (i == 2) ? 2048 : 0;
         sr_req_i = 1'b1;
         base = ref_cnt;
         wait_until(1, 1);
         check(in_sr, 1'b1);
         check(32'(ref_cnt - base), 32'(burst_n));
         repeat (4) @(negedge clk_sys_i);
         repeat (2 + ($unsigned($random(seed)) % 24))
         begin
            @(negedge clk_sys_i);
            check(mem_clk_o, 1'b0);
         end
         sr_req_i = 1'b0;
         wait_until(1, 0);
         wait_until(2, base + 2 * burst_n);
         repeat (40) @(negedge clk_sys_i);
         check(in_sr, 1'b0);
         check(32'(err_cnt), 32'h0);
      end
      end_sim();
   end
endmodule
